// *** pkg/gpr_pkg.sv ***
package gpr_pkg;

	// Geometry
	localparam int GPR_NUM_PORTS = 4;
	localparam int GPR_PORT_W    = 8;
	localparam int GPR_IDX_W     = 6;
	localparam int GPR_ADDR_W    = 8;
	localparam int GPR_DATA_W    = 32;
	localparam int GPR_SYNC_STAGES = 2;

	// Register indices; byte address is four times the index
	localparam logic [GPR_IDX_W-1:0] GPR_GPIO_A_IN_IDX   = 6'h00;
	localparam logic [GPR_IDX_W-1:0] GPR_GPIO_A_DIR_IDX  = 6'h01;
	localparam logic [GPR_IDX_W-1:0] GPR_GPIO_A_OUT_IDX  = 6'h02;
	localparam logic [GPR_IDX_W-1:0] GPR_GPIO_B_IN_IDX   = 6'h03;
	localparam logic [GPR_IDX_W-1:0] GPR_GPIO_B_DIR_IDX  = 6'h04;
	localparam logic [GPR_IDX_W-1:0] GPR_GPIO_B_OUT_IDX  = 6'h05;
	localparam logic [GPR_IDX_W-1:0] GPR_GPIO_C_IN_IDX   = 6'h06;
	localparam logic [GPR_IDX_W-1:0] GPR_GPIO_C_DIR_IDX  = 6'h07;
	localparam logic [GPR_IDX_W-1:0] GPR_GPIO_C_OUT_IDX  = 6'h08;
	localparam logic [GPR_IDX_W-1:0] GPR_GPIO_D_IN_IDX   = 6'h09;
	localparam logic [GPR_IDX_W-1:0] GPR_GPIO_D_DIR_IDX  = 6'h0a;
	localparam logic [GPR_IDX_W-1:0] GPR_GPIO_D_OUT_IDX  = 6'h0b;
	localparam logic [GPR_IDX_W-1:0] GPR_MCU_CONTROL_IDX = 6'h35;

	localparam logic [GPR_IDX_W-1:0] GPR_IN_IDX  [GPR_NUM_PORTS] = '{
		GPR_GPIO_A_IN_IDX, GPR_GPIO_B_IN_IDX, GPR_GPIO_C_IN_IDX, GPR_GPIO_D_IN_IDX};
	localparam logic [GPR_IDX_W-1:0] GPR_DIR_IDX [GPR_NUM_PORTS] = '{
		GPR_GPIO_A_DIR_IDX, GPR_GPIO_B_DIR_IDX, GPR_GPIO_C_DIR_IDX, GPR_GPIO_D_DIR_IDX};
	localparam logic [GPR_IDX_W-1:0] GPR_OUT_IDX [GPR_NUM_PORTS] = '{
		GPR_GPIO_A_OUT_IDX, GPR_GPIO_B_OUT_IDX, GPR_GPIO_C_OUT_IDX, GPR_GPIO_D_OUT_IDX};

	// Control register fields
	localparam int GPR_DEBUG_PORT_DISABLE_BIT   = 7;
	localparam int GPR_PULLUP_GLOBAL_OFF_BIT    = 4;
	localparam int GPR_VECTOR_TABLE_SELECT_BIT  = 1;
	localparam int GPR_VECTOR_CHANGE_ENABLE_BIT = 0;
	localparam logic [GPR_PORT_W-1:0] GPR_CTRL_WMASK = 8'h93;

	// Reset values
	localparam logic [GPR_PORT_W-1:0] GPR_CTRL_RST = 8'h00;
	localparam logic [GPR_PORT_W-1:0] GPR_DIR_RST  = 8'h00;
	localparam logic [GPR_PORT_W-1:0] GPR_OUT_RST  = 8'h00;
	localparam logic [GPR_PORT_W-1:0] GPR_SYNC_RST = 8'h00;
	localparam logic [GPR_DATA_W-1:0] GPR_RDATA_RST = 32'h0000_0000;

	typedef logic [GPR_PORT_W-1:0] gpr_byte_type;

endpackage : gpr_pkg

// *** pkg/gpr_port_if.sv ***
`timescale 1ns/10ps
interface gpr_port_if;
	import gpr_pkg::*;

	logic         wr_dir;
	logic         wr_out;
	gpr_byte_type wdata;
	logic         pullup_off;
	gpr_byte_type dir;
	gpr_byte_type out;
	gpr_byte_type level;

	modport port (input wr_dir, wr_out, wdata, pullup_off, output dir, out, level);
	modport ctrl (output wr_dir, wr_out, wdata, pullup_off, input dir, out, level);

endinterface : gpr_port_if

// *** src/gpr_sync.sv ***
`timescale 1ns/10ps
module gpr_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Asynchronous in, synchronous out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	import gpr_pkg::*;

	logic [WIDTH-1:0] stage1;

	// Stage1 is read only by the second flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule : gpr_sync

// *** src/gpr_port.sv ***
`timescale 1ns/10ps
module gpr_port (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// Register side
	gpr_port_if.port                regs,
	// Pins
	input  wire gpr_pkg::gpr_byte_type pin_in,
	output gpr_pkg::gpr_byte_type      pad_out,
	output gpr_pkg::gpr_byte_type      pad_oe,
	output gpr_pkg::gpr_byte_type      pad_pu
);
	import gpr_pkg::*;

	gpr_byte_type next_pu;

	// Pull-up only on an input pin with its output bit set
	assign next_pu = ~pad_oe & pad_out & {GPR_PORT_W{~regs.pullup_off}};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_oe  <= GPR_DIR_RST;
			pad_out <= GPR_OUT_RST;
			pad_pu  <= '0;
		end else begin
			if (regs.wr_dir)
				pad_oe <= regs.wdata;
			if (regs.wr_out)
				pad_out <= regs.wdata;
			pad_pu <= next_pu;
		end
	end

	assign regs.dir = pad_oe;
	assign regs.out = pad_out;

	// Pins are asynchronous to pclk
	gpr_sync #(.WIDTH(GPR_PORT_W)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (pin_in),
		.sync_out (regs.level)
	);

	property p_level_sync;
		@(posedge pclk) disable iff (!presetn)
		$past(presetn, 2) |-> regs.level == $past(pin_in, 2);
	endproperty
	a_level_sync: assert property (p_level_sync)
		else $error("Input level is not the pin two cycles back");

	property p_pullup_cause;
		@(posedge pclk) disable iff (!presetn)
		(pad_pu != '0) |-> (($past(pad_out) & ~$past(pad_oe)) & pad_pu) == pad_pu
			&& !$past(regs.pullup_off);
	endproperty
	a_pullup_cause: assert property (p_pullup_cause)
		else $error("Pull-up enabled without input direction and output bit");

	property p_dir_write;
		@(posedge pclk) disable iff (!presetn)
		regs.wr_dir |=> pad_oe == $past(regs.wdata) ##1 $stable(pad_oe) || $past(regs.wr_dir);
	endproperty
	a_dir_write: assert property (p_dir_write)
		else $error("Direction write not reflected on output enables");

endmodule : gpr_port

// *** src/gpr_gpio.sv ***
// Added by the designer: register access over APB.
`timescale 1ns/10ps
// Functional notes
// - Global pull-up off bit forces all pull-ups off regardless of direction and output bits.
// - Control register holds bits 7, 4, 1, 0; others read zero; resets zero.
// - Port A input, direction, output registers decode at indices 0x00, 0x01, 0x02.
// - Port B input, direction, output registers decode at indices 0x03, 0x04, 0x05.
// - Port C input, direction, output registers decode at indices 0x06, 0x07, 0x08.
// - Port D input, direction, output registers decode at indices 0x09, 0x0a, 0x0b.
// - Direction and output registers are fully read/write and reset to zero.
// - Input-level registers are eight bits, ignore writes, follow the pins.
module gpr_gpio (
	// APB clock and reset
	input  wire logic                                   pclk,
	input  wire logic                                   presetn,
	// APB slave
	input  wire logic                                   psel,
	input  wire logic                                   penable,
	input  wire logic                                   pwrite,
	input  wire logic [gpr_pkg::GPR_ADDR_W-1:0]         paddr,
	input  wire logic [gpr_pkg::GPR_DATA_W-1:0]         pwdata,
	input  wire logic [3:0]                             pstrb,
	output logic      [gpr_pkg::GPR_DATA_W-1:0]         prdata,
	output logic                                        pready,
	output logic                                        pslverr,
	// Port pins
	input  wire gpr_pkg::gpr_byte_type [gpr_pkg::GPR_NUM_PORTS-1:0] pin_in,
	output gpr_pkg::gpr_byte_type      [gpr_pkg::GPR_NUM_PORTS-1:0] pin_out,
	output gpr_pkg::gpr_byte_type      [gpr_pkg::GPR_NUM_PORTS-1:0] pin_oe,
	output gpr_pkg::gpr_byte_type      [gpr_pkg::GPR_NUM_PORTS-1:0] pin_pullup_en,
	// System control bits
	output logic                                        debug_port_disable,
	output logic                                        vector_table_select,
	output logic                                        vector_select_change_enable
);
	import gpr_pkg::*;

	function automatic logic reg_hit(input logic [GPR_IDX_W-1:0] idx,
		input logic [GPR_IDX_W-1:0] target, input logic word_aligned);
		reg_hit = word_aligned && (idx == target);
	endfunction : reg_hit

	// Bus decode
	wire logic [GPR_IDX_W-1:0] reg_idx;
	wire logic                 aligned;
	wire logic                 access;
	wire logic                 wr_ok;
	wire logic                 rd_prep;
	wire logic                 hit_ctrl;
	wire logic                 mapped;

	assign reg_idx  = paddr[GPR_ADDR_W-1:2];
	assign aligned  = (paddr[1:0] == 2'h0);
	assign access   = psel && penable;
	// Write lands only at the edge where pready is sampled high
	assign wr_ok    = access && pready && pwrite && pstrb[0];
	assign rd_prep  = access && !pready;
	assign hit_ctrl = reg_hit(reg_idx, GPR_MCU_CONTROL_IDX, aligned);

	logic [GPR_NUM_PORTS-1:0] hit_in;
	logic [GPR_NUM_PORTS-1:0] hit_dir;
	logic [GPR_NUM_PORTS-1:0] hit_out;
	gpr_byte_type             dir_all   [GPR_NUM_PORTS];
	gpr_byte_type             out_all   [GPR_NUM_PORTS];
	gpr_byte_type             level_all [GPR_NUM_PORTS];
	gpr_byte_type             ctrl;

	genvar gi;
	generate
		for (gi = 0; gi < GPR_NUM_PORTS; gi++) begin : g_port
			gpr_port_if port_bus ();

			assign hit_in[gi]  = reg_hit(reg_idx, GPR_IN_IDX[gi], aligned);
			assign hit_dir[gi] = reg_hit(reg_idx, GPR_DIR_IDX[gi], aligned);
			assign hit_out[gi] = reg_hit(reg_idx, GPR_OUT_IDX[gi], aligned);

			assign port_bus.wr_dir     = wr_ok && hit_dir[gi];
			assign port_bus.wr_out     = wr_ok && hit_out[gi];
			assign port_bus.wdata      = pwdata[GPR_PORT_W-1:0];
			assign port_bus.pullup_off = ctrl[GPR_PULLUP_GLOBAL_OFF_BIT];
			assign dir_all[gi]         = port_bus.dir;
			assign out_all[gi]         = port_bus.out;
			assign level_all[gi]       = port_bus.level;

			gpr_port u_port (
				.pclk    (pclk),
				.presetn (presetn),
				.regs    (port_bus.port),
				.pin_in  (pin_in[gi]),
				.pad_out (pin_out[gi]),
				.pad_oe  (pin_oe[gi]),
				.pad_pu  (pin_pullup_en[gi])
			);
		end
	endgenerate

	assign mapped = hit_ctrl || (|hit_in) || (|hit_dir) || (|hit_out);

	// Read mux; unmapped reads give zero
	gpr_byte_type next_rbyte;
	always_comb begin
		next_rbyte = hit_ctrl ? ctrl : '0;
		for (int p = 0; p < GPR_NUM_PORTS; p++) begin
			if (hit_in[p])
				next_rbyte = level_all[p];
			if (hit_dir[p])
				next_rbyte = dir_all[p];
			if (hit_out[p])
				next_rbyte = out_all[p];
		end
	end

	// One wait state: read data is registered on the same edge that raises pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= GPR_RDATA_RST;
		end else begin
			pready  <= rd_prep;
			pslverr <= rd_prep && !mapped;
			if (rd_prep)
				prdata <= {{(GPR_DATA_W-GPR_PORT_W){1'b0}}, next_rbyte};
		end
	end

	// Control register: writes keep bits 7, 4, 1, 0 and clear the rest
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl <= GPR_CTRL_RST;
		else if (wr_ok && hit_ctrl)
			ctrl <= pwdata[GPR_PORT_W-1:0] & GPR_CTRL_WMASK;
	end

	assign debug_port_disable          = ctrl[GPR_DEBUG_PORT_DISABLE_BIT];
	assign vector_table_select         = ctrl[GPR_VECTOR_TABLE_SELECT_BIT];
	assign vector_select_change_enable = ctrl[GPR_VECTOR_CHANGE_ENABLE_BIT];

	// Checks
	sequence s_setup;
		psel && !penable;
	endsequence

	sequence s_done_read(logic [GPR_IDX_W-1:0] idx);
		access && pready && !pwrite && aligned && reg_idx == idx;
	endsequence

	sequence s_done_write(logic [GPR_IDX_W-1:0] idx);
		access && pready && pwrite && pstrb[0] && aligned && reg_idx == idx;
	endsequence

	property p_pullup_off;
		@(posedge pclk) disable iff (!presetn)
		ctrl[GPR_PULLUP_GLOBAL_OFF_BIT] |=> pin_pullup_en == '0;
	endproperty
	a_pullup_off: assert property (p_pullup_off)
		else $error("Pull-up active while global pull-up off is set");

	property p_ctrl_write;
		@(posedge pclk) disable iff (!presetn)
		s_done_write(GPR_MCU_CONTROL_IDX) |=> ctrl == ($past(pwdata[7:0]) & 8'h93);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("Control register write wrong or reserved bit set");

	property p_read_a_out;
		@(posedge pclk) disable iff (!presetn)
		s_done_read(GPR_GPIO_A_OUT_IDX) |-> prdata == {24'h000000, $past(out_all[0])};
	endproperty
	a_read_a_out: assert property (p_read_a_out)
		else $error("Port A output register read mismatch");

	property p_write_b_dir;
		@(posedge pclk) disable iff (!presetn)
		s_done_write(GPR_GPIO_B_DIR_IDX) |=> dir_all[1] == $past(pwdata[7:0])
			##1 pin_pullup_en[1] == (~$past(pin_oe[1]) & $past(pin_out[1])
			& {8{~$past(ctrl[GPR_PULLUP_GLOBAL_OFF_BIT])}});
	endproperty
	a_write_b_dir: assert property (p_write_b_dir)
		else $error("Port B direction write not taken");

	property p_read_c_in;
		@(posedge pclk) disable iff (!presetn)
		s_done_read(GPR_GPIO_C_IN_IDX) |-> prdata[7:0] == $past(level_all[2])
			&& prdata[31:8] == 24'h000000;
	endproperty
	a_read_c_in: assert property (p_read_c_in)
		else $error("Port C input-level read mismatch");

	property p_write_d_out;
		@(posedge pclk) disable iff (!presetn)
		s_done_write(GPR_GPIO_D_OUT_IDX) |=> pin_out[3] == $past(pwdata[7:0]);
	endproperty
	a_write_d_out: assert property (p_write_d_out)
		else $error("Port D output write not on pins");

	property p_regs_hold;
		@(posedge pclk) disable iff (!presetn)
		!(wr_ok && (|hit_dir || |hit_out)) |=> $stable(pin_out) && $stable(pin_oe);
	endproperty
	a_regs_hold: assert property (p_regs_hold)
		else $error("Direction or output changed without a write");

	property p_in_write_ignored;
		@(posedge pclk) disable iff (!presetn)
		s_done_write(GPR_GPIO_A_IN_IDX) |=> $stable(pin_out[0]) && $stable(pin_oe[0])
			&& !pslverr;
	endproperty
	a_in_write_ignored: assert property (p_in_write_ignored)
		else $error("Input-level write disturbed port A");

	property p_wait_state;
		@(posedge pclk) disable iff (!presetn)
		s_setup ##1 (psel && penable) |-> !pready ##1 pready ##1 !pready;
	endproperty
	a_wait_state: assert property (p_wait_state)
		else $error("Access did not complete after exactly one wait state");

	property p_unmapped;
		@(posedge pclk) disable iff (!presetn)
		(access && pready && !mapped) |-> pslverr && (pwrite || prdata == 32'h00000000);
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("Unmapped access not flagged");

	property p_ctrl_reserved;
		@(posedge pclk) disable iff (!presetn)
		(ctrl & ~GPR_CTRL_WMASK) == 8'h00;
	endproperty
	a_ctrl_reserved: assert property (p_ctrl_reserved)
		else $error("Reserved control bit set");

	property p_ctrl_hold;
		@(posedge pclk) disable iff (!presetn)
		!(wr_ok && hit_ctrl) |=> $stable(ctrl);
	endproperty
	a_ctrl_hold: assert property (p_ctrl_hold)
		else $error("Control register changed without a write");

	property p_read_ctrl;
		@(posedge pclk) disable iff (!presetn)
		s_done_read(GPR_MCU_CONTROL_IDX) |-> prdata == {24'h000000, $past(ctrl)};
	endproperty
	a_read_ctrl: assert property (p_read_ctrl)
		else $error("Control register read mismatch");

	property p_read_b_out;
		@(posedge pclk) disable iff (!presetn)
		s_done_read(GPR_GPIO_B_OUT_IDX) |-> prdata == {24'h000000, $past(out_all[1])};
	endproperty
	a_read_b_out: assert property (p_read_b_out)
		else $error("Port B output register read mismatch");

	property p_read_c_dir;
		@(posedge pclk) disable iff (!presetn)
		s_done_read(GPR_GPIO_C_DIR_IDX) |-> prdata == {24'h000000, $past(dir_all[2])};
	endproperty
	a_read_c_dir: assert property (p_read_c_dir)
		else $error("Port C direction register read mismatch");

	property p_read_d_in;
		@(posedge pclk) disable iff (!presetn)
		s_done_read(GPR_GPIO_D_IN_IDX) |-> prdata[7:0] == $past(level_all[3]);
	endproperty
	a_read_d_in: assert property (p_read_d_in)
		else $error("Port D input-level read mismatch");

	property p_write_a_out;
		@(posedge pclk) disable iff (!presetn)
		s_done_write(GPR_GPIO_A_OUT_IDX) |=> pin_out[0] == $past(pwdata[7:0]);
	endproperty
	a_write_a_out: assert property (p_write_a_out)
		else $error("Port A output write not on pins");

	property p_write_c_dir;
		@(posedge pclk) disable iff (!presetn)
		s_done_write(GPR_GPIO_C_DIR_IDX) |=> pin_oe[2] == $past(pwdata[7:0]);
	endproperty
	a_write_c_dir: assert property (p_write_c_dir)
		else $error("Port C direction write not on output enables");

	property p_read_upper_zero;
		@(posedge pclk) disable iff (!presetn)
		(access && pready && !pwrite) |-> prdata[31:8] == 24'h000000;
	endproperty
	a_read_upper_zero: assert property (p_read_upper_zero)
		else $error("Read data above the register byte not zero");

	property p_strobe_off;
		@(posedge pclk) disable iff (!presetn)
		(access && pready && pwrite && !pstrb[0])
			|=> $stable(ctrl) && $stable(pin_out) && $stable(pin_oe);
	endproperty
	a_strobe_off: assert property (p_strobe_off)
		else $error("Write without byte strobe changed a register");

	property p_pready_pulse;
		@(posedge pclk) disable iff (!presetn)
		pready |=> !pready;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse)
		else $error("Ready held for more than one cycle");

	property p_pullup_on;
		@(posedge pclk) disable iff (!presetn)
		!ctrl[GPR_PULLUP_GLOBAL_OFF_BIT] |=> pin_pullup_en == (~$past(pin_oe) & $past(pin_out));
	endproperty
	a_pullup_on: assert property (p_pullup_on)
		else $error("Pull-up not following direction and output bits");

	property p_misaligned;
		@(posedge pclk) disable iff (!presetn)
		(access && pready && !aligned) |-> pslverr;
	endproperty
	a_misaligned: assert property (p_misaligned)
		else $error("Misaligned access not flagged");

endmodule : gpr_gpio

// *** verification/gpr_pins.sv ***
`timescale 1ns/10ps
module gpr_pins (
	// Clock
	input  wire logic                                            pclk,
	// Device side
	input  wire gpr_pkg::gpr_byte_type [gpr_pkg::GPR_NUM_PORTS-1:0] pin_out,
	input  wire gpr_pkg::gpr_byte_type [gpr_pkg::GPR_NUM_PORTS-1:0] pin_oe,
	input  wire gpr_pkg::gpr_byte_type [gpr_pkg::GPR_NUM_PORTS-1:0] pin_pullup_en,
	// Outside drivers
	input  wire gpr_pkg::gpr_byte_type [gpr_pkg::GPR_NUM_PORTS-1:0] ext_val,
	input  wire gpr_pkg::gpr_byte_type [gpr_pkg::GPR_NUM_PORTS-1:0] ext_en,
	// Resolved levels
	output gpr_pkg::gpr_byte_type      [gpr_pkg::GPR_NUM_PORTS-1:0] pin_in
);
	import gpr_pkg::*;
	// Undriven pins wander every cycle so a stale value never passes
	gpr_byte_type flt = 8'h5a;
	always @(posedge pclk) begin
		flt <= ~flt;
	end
	always_comb begin
		for (int p = 0; p < GPR_NUM_PORTS; p++) begin
			pin_in[p] = (pin_oe[p] & pin_out[p]) | (~pin_oe[p] & ext_en[p] & ext_val[p])
				| (~pin_oe[p] & ~ext_en[p] & pin_pullup_en[p])
				| (~pin_oe[p] & ~ext_en[p] & ~pin_pullup_en[p] & flt);
		end
	end
endmodule : gpr_pins

// *** verification/gpr_gpio_tb.sv ***
`timescale 1ns/10ps
module gpr_gpio_tb;
	import gpr_pkg::*;
	logic                               pclk = 1'b0;
	logic                               presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]                         paddr;
	logic [31:0]                        pwdata, prdata, rdat, lfsr_state;
	logic [3:0]                         pstrb;
	gpr_byte_type [GPR_NUM_PORTS-1:0]   pin_in, pin_out, pin_oe, pin_pullup_en, ext_val, ext_en;
	logic                               debug_port_disable, vector_table_select;
	logic                               vector_select_change_enable;
	gpr_byte_type                       dir_m [4];
	gpr_byte_type                       out_m [4];
	gpr_byte_type                       ctrl_m, v;
	int                                 fail_count, n_tests;
	always #12.5 pclk = ~pclk;
	gpr_gpio gpr_gpio_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .debug_port_disable(debug_port_disable),
		.vector_table_select(vector_table_select),
		.vector_select_change_enable(vector_select_change_enable));
	gpr_pins gpr_pins_i (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup_en(pin_pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
	function automatic gpr_byte_type rnd8();
		lfsr_state = {lfsr_state[30:0],
			lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
		return lfsr_state[7:0];
	endfunction : rnd8
	function automatic gpr_byte_type exp_pu(input int p);
		return ~dir_m[p] & out_m[p] & {8{~ctrl_m[GPR_PULLUP_GLOBAL_OFF_BIT]}};
	endfunction : exp_pu
	function automatic gpr_byte_type exp_lvl(input int p);
		return (dir_m[p] & out_m[p]) | (~dir_m[p] & ext_val[p]);
	endfunction : exp_lvl
	task complete_run();
		if (fail_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run
	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: read %h, want %h", $time, got, exp);
		end
	endtask : chk_word
	task chk_pin(input gpr_byte_type got, input gpr_byte_type exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: pins %h, want %h", $time, got, exp);
		end
	endtask : chk_pin
	task chk_flag(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: flag %b, want %b", $time, got, exp);
		end
	endtask : chk_flag
	// One idle edge first so psel is never assigned twice in a step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge pclk);
		penable <= 1'b1;
		// No assumed latency; a hang is ended by the watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [5:0] idx, input gpr_byte_type d);
		apb(1'b1, {idx, 2'b00}, {24'h0, d}, 4'hf);
		for (int p = 0; p < 4; p++) begin
			if (idx == GPR_DIR_IDX[p]) dir_m[p] = d;
			if (idx == GPR_OUT_IDX[p]) out_m[p] = d;
		end
		if (idx == GPR_MCU_CONTROL_IDX) ctrl_m = d & 8'h93;
	endtask : wr
	task rd_chk(input logic [5:0] idx, input gpr_byte_type exp);
		apb(1'b0, {idx, 2'b00}, 32'h0, 4'h0);
		chk_word(rdat, {24'h0, exp});
		chk_flag(err, 1'b0);
	endtask : rd_chk
	task check_pins();
		repeat (3) @(posedge pclk);
		for (int p = 0; p < 4; p++) begin
			chk_pin(pin_oe[p], dir_m[p]);
			chk_pin(pin_out[p], out_m[p]);
			chk_pin(pin_pullup_en[p], exp_pu(p));
		end
	endtask : check_pins
	task regs_all();
		for (int p = 0; p < 4; p++) begin
			rd_chk(GPR_DIR_IDX[p], dir_m[p]);
			rd_chk(GPR_OUT_IDX[p], out_m[p]);
		end
		rd_chk(GPR_MCU_CONTROL_IDX, ctrl_m);
		check_pins();
	endtask : regs_all
	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{ext_val, ext_en, fail_count, n_tests, ctrl_m} = '0;
		dir_m = '{default: 8'h00};
		out_m = '{default: 8'h00};
		lfsr_state = 32'ha4cdfbd9;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		regs_all();
		for (int i = 0; i < 6; i++) begin
			for (int p = 0; p < 4; p++) begin
				wr(GPR_DIR_IDX[p], i == 0 ? 8'hff : rnd8());
				wr(GPR_OUT_IDX[p], i == 0 ? 8'hff : rnd8());
				wr(GPR_IN_IDX[p], rnd8());
			end
			regs_all();
		end
		for (int i = 0; i < 32; i++) begin
			v = i < 4 ? 8'hff >> (i * 2) : rnd8();
			wr(GPR_MCU_CONTROL_IDX, v);
			rd_chk(GPR_MCU_CONTROL_IDX, v & 8'h93);
			chk_flag(debug_port_disable, v[7]);
			chk_flag(vector_table_select, v[1]);
			chk_flag(vector_select_change_enable, v[0]);
		end
		for (int k = 0; k < 2; k++) begin
			for (int p = 0; p < 4; p++) begin
				wr(GPR_DIR_IDX[p], 8'h00);
				wr(GPR_OUT_IDX[p], 8'hff);
			end
			wr(GPR_MCU_CONTROL_IDX, k ? 8'h10 : 8'h00);
			check_pins();
			for (int p = 0; p < 4; p++)
				if (!k) rd_chk(GPR_IN_IDX[p], 8'hff);
		end
		for (int i = 0; i < 8; i++)
			for (int p = 0; p < 4; p++) begin
				wr(GPR_DIR_IDX[p], rnd8());
				wr(GPR_OUT_IDX[p], rnd8());
				ext_en[p]  <= ~dir_m[p];
				ext_val[p] <= rnd8();
				repeat (4) @(posedge pclk);
				rd_chk(GPR_IN_IDX[p], exp_lvl(p));
			end
		apb(1'b1, 8'h30, 32'h5a, 4'hf);
		chk_flag(err, 1'b1);
		apb(1'b0, 8'h30, 32'h0, 4'h0);
		chk_word(rdat, 32'h0);
		chk_flag(err, 1'b1);
		apb(1'b1, 8'h11, 32'haa, 4'hf);
		chk_flag(err, 1'b1);
		apb(1'b1, {GPR_DIR_IDX[0], 2'b00}, ~{24'h0, dir_m[0]}, 4'h0);
		chk_flag(err, 1'b0);
		regs_all();
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		complete_run();
	end
endmodule : gpr_gpio_tb
